// >>> hw/mfs_supervisor.sv
`timescale 1ns/100ps
module mfs_supervisor
  import mfs_pkg::*;
#(
  parameter int          VW         = 16,
  parameter longint      EXT_QUAL   = mfs_pkg::MFS_EXT_QUAL_CYC,
  parameter longint      DLY_UNIT   = mfs_pkg::MFS_DLY_UNIT_CYC
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rst_n,
  // Register port
  input  wire logic [3:0]    reg_addr,
  input  wire logic [15:0]   reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output logic      [15:0]   reg_rdata,
  // Sensing front ends
  input  wire logic [VW-1:0] line_volt,
  input  wire logic [2:0]    phase_present,
  input  wire logic          phase_seq_ok,
  input  wire logic [2:0]    load_conn_ok,
  input  wire logic          scr_shorted,
  input  wire logic [15:0]   heatsink_temp,
  input  wire logic          aux_contact,
  // Parameter storage
  input  wire logic          param_xfer_fail,
  input  wire logic          key_mode_up,
  input  wire logic          key_mode_store,
  output logic               param_load_default,
  output logic               param_store,
  // Starter outputs
  output logic               motor_stop,
  output logic               start_block,
  output logic               fault_led,
  output logic               fault_relay,
  output logic [3:0]         trip_code,
  output logic               irq
);
  import mfs_pkg::*;

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  localparam int SW = VW + 3 + 1 + 3 + 1 + 16 + 1 + 1 + 2;
  logic [SW-1:0] s1_q, s1_d, s2_q, s2_d;
  logic [VW-1:0] v_s;
  logic [2:0]    ph_s, conn_s;
  logic          seq_s, scr_s, aux_s, xf_s, k1_s, k2_s;
  logic [15:0]   temp_s;

  always_comb begin
    s1_d = {line_volt, phase_present, phase_seq_ok, load_conn_ok, scr_shorted,
            heatsink_temp, aux_contact, param_xfer_fail, key_mode_up, key_mode_store};
    s2_d = s1_q;
  end
  always_ff @(posedge clk) begin
    s1_q <= s1_d;
    s2_q <= s2_d;
  end
  assign {v_s, ph_s, seq_s, conn_s, scr_s, temp_s, aux_s, xf_s, k1_s, k2_s} = s2_q;

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [MFS_NFLT-1:0] stat_q, stat_d, mask_q, mask_d, trip_q, trip_d;
  logic [15:0]         uvl_q, uvl_d, uvd_q, uvd_d, ovl_q, ovl_d, ovd_q, ovd_d;
  logic [1:0]          aux_q, aux_d;
  logic                blk_q, blk_d;
  logic [15:0]         rd_q, rd_d;
  logic                clr;
  logic [MFS_NFLT-1:0] ev;

  // ---------------------------------------------------------------
  // Fault detection
  // ---------------------------------------------------------------
  logic [31:0] uvc_q, uvc_d, ovc_q, ovc_d, extc_q, extc_d;
  logic [31:0] uvt_q, uvt_d, ovt_q, ovt_d;
  logic        gen_mode, under, over, k_prev_q, k_prev_d, k_hit;

  assign gen_mode = (aux_q == MFS_AUX_GEN);
  assign under    = v_s < VW'(uvl_q);
  assign over     = v_s > VW'(ovl_q);
  assign k_hit    = k1_s & k2_s & ~k_prev_q;

  always_comb begin
    // Delay timers count in units, then units against the set delay.
    uvt_d = 32'h0;
    uvc_d = 32'h0;
    if (under) begin
      uvt_d = (uvt_q >= 32'(DLY_UNIT - 1)) ? 32'h0 : uvt_q + 32'h1;
      uvc_d = (uvt_q >= 32'(DLY_UNIT - 1) && uvc_q < {16'h0, uvd_q}) ? uvc_q + 32'h1 : uvc_q;
    end
    ovt_d = 32'h0;
    ovc_d = 32'h0;
    if (over) begin
      ovt_d = (ovt_q >= 32'(DLY_UNIT - 1)) ? 32'h0 : ovt_q + 32'h1;
      ovc_d = (ovt_q >= 32'(DLY_UNIT - 1) && ovc_q < {16'h0, ovd_q}) ? ovc_q + 32'h1 : ovc_q;
    end
    extc_d = 32'h0;
    if (aux_s && !gen_mode) begin
      extc_d = (extc_q > 32'(EXT_QUAL)) ? extc_q : extc_q + 32'h1;
    end
    k_prev_d = k1_s & k2_s;
    ev = '0;
    ev[MFS_F_UV]     = under && (uvc_q >= {16'h0, uvd_q});
    ev[MFS_F_ZEROV]  = (v_s == '0);
    ev[MFS_F_OV]     = over && (ovc_q >= {16'h0, ovd_q});
    ev[MFS_F_PLOSS]  = (ph_s != 3'b111) && (ph_s != 3'b000);
    ev[MFS_F_PSEQ]   = (ph_s == 3'b111) && !seq_s;
    ev[MFS_F_CONN]   = !gen_mode && ((conn_s != 3'b111) || scr_s);
    ev[MFS_F_OVTEMP] = temp_s > MFS_TEMP_LIMIT;
    ev[MFS_F_EXT]    = extc_q > 32'(EXT_QUAL);
    ev[MFS_F_WRPAR]  = xf_s;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      uvt_q    <= 32'h0;
      uvc_q    <= 32'h0;
      ovt_q    <= 32'h0;
      ovc_q    <= 32'h0;
      extc_q   <= 32'h0;
      k_prev_q <= 1'b0;
    end else begin
      uvt_q    <= uvt_d;
      uvc_q    <= uvc_d;
      ovt_q    <= ovt_d;
      ovc_q    <= ovc_d;
      extc_q   <= extc_d;
      k_prev_q <= k_prev_d;
    end
  end

  // ---------------------------------------------------------------
  // Register file, trip latch and interrupt status
  // ---------------------------------------------------------------
  always_comb begin
    clr    = reg_wr && (reg_addr == MFS_OFF_CTRL) && reg_wdata[MFS_C_RESET];
    mask_d = mask_q;
    uvl_d  = uvl_q;
    uvd_d  = uvd_q;
    ovl_d  = ovl_q;
    ovd_d  = ovd_q;
    aux_d  = aux_q;
    if (reg_wr) begin
      unique case (reg_addr)
        MFS_OFF_MASK:   mask_d = reg_wdata[MFS_NFLT-1:0];
        MFS_OFF_UV_LVL: uvl_d  = reg_wdata;
        MFS_OFF_UV_DLY: uvd_d  = reg_wdata;
        MFS_OFF_OV_LVL: ovl_d  = reg_wdata;
        MFS_OFF_OV_DLY: ovd_d  = reg_wdata;
        MFS_OFF_AUXCFG: aux_d  = reg_wdata[1:0];
        default:        ;
      endcase
    end
    // A live fault re-latches even in the cycle of the reset command.
    trip_d = (clr ? '0 : trip_q) | ev;
    blk_d  = (clr ? 1'b0 : blk_q) | ev[MFS_F_CONN];
    stat_d = ((reg_rd && reg_addr == MFS_OFF_STATUS) ? '0 : stat_q) | ev;
    rd_d   = 16'h0;
    if (reg_rd) begin
      unique case (reg_addr)
        MFS_OFF_STATUS: rd_d = 16'(stat_q);
        MFS_OFF_MASK:   rd_d = 16'(mask_q);
        MFS_OFF_TRIP:   rd_d = 16'(trip_q);
        MFS_OFF_UV_LVL: rd_d = uvl_q;
        MFS_OFF_UV_DLY: rd_d = uvd_q;
        MFS_OFF_OV_LVL: rd_d = ovl_q;
        MFS_OFF_OV_DLY: rd_d = ovd_q;
        MFS_OFF_AUXCFG: rd_d = {14'h0, aux_q};
        MFS_OFF_CTRL:   rd_d = {15'h0, blk_q};
        default:        rd_d = 16'h0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stat_q <= '0;
      mask_q <= '0;
      trip_q <= '0;
      blk_q  <= 1'b0;
      uvl_q  <= MFS_UV_LVL_RST;
      uvd_q  <= MFS_DLY_RST;
      ovl_q  <= MFS_OV_LVL_RST;
      ovd_q  <= MFS_DLY_RST;
      aux_q  <= MFS_AUX_EXTFLT;
      rd_q   <= 16'h0;
    end else begin
      stat_q <= stat_d;
      mask_q <= mask_d;
      trip_q <= trip_d;
      blk_q  <= blk_d;
      uvl_q  <= uvl_d;
      uvd_q  <= uvd_d;
      ovl_q  <= ovl_d;
      ovd_q  <= ovd_d;
      aux_q  <= aux_d;
      rd_q   <= rd_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  logic [3:0] code_d, code_q;
  logic       ld_q, st_q, ld_d, st_d;

  always_comb begin
    // Lowest set fault bit names the trip; code 0 means no trip.
    code_d = 4'h0;
    for (int i = MFS_NFLT - 1; i >= 0; i--) begin
      if (trip_q[i]) begin
        code_d = 4'(i + 1);
      end
    end
    ld_d = k_hit || (reg_wr && reg_addr == MFS_OFF_CTRL && reg_wdata[MFS_C_DEFLOAD]);
    st_d = ld_q;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      code_q <= 4'h0;
      ld_q   <= 1'b0;
      st_q   <= 1'b0;
    end else begin
      code_q <= code_d;
      ld_q   <= ld_d;
      st_q   <= st_d;
    end
  end

  assign motor_stop         = |trip_q;
  assign fault_led          = |trip_q;
  assign fault_relay        = |trip_q;
  assign start_block        = blk_q;
  assign trip_code          = code_q;
  assign param_load_default = ld_q;
  assign param_store        = st_q;
  assign reg_rdata          = rd_q;
  assign irq                = |(stat_q & mask_q);

endmodule

// >>> common/mfs_pkg.sv
package mfs_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [3:0] MFS_OFF_STATUS  = 4'h0;
  localparam logic [3:0] MFS_OFF_MASK    = 4'h1;
  localparam logic [3:0] MFS_OFF_TRIP    = 4'h2;
  localparam logic [3:0] MFS_OFF_UV_LVL  = 4'h3;
  localparam logic [3:0] MFS_OFF_UV_DLY  = 4'h4;
  localparam logic [3:0] MFS_OFF_OV_LVL  = 4'h5;
  localparam logic [3:0] MFS_OFF_OV_DLY  = 4'h6;
  localparam logic [3:0] MFS_OFF_AUXCFG  = 4'h7;
  localparam logic [3:0] MFS_OFF_CTRL    = 4'h8;

  // ---------------------------------------------------------------
  // Fault bit positions
  // ---------------------------------------------------------------
  localparam int MFS_NFLT       = 9;
  localparam int MFS_F_UV       = 0;
  localparam int MFS_F_ZEROV    = 1;
  localparam int MFS_F_OV       = 2;
  localparam int MFS_F_PLOSS    = 3;
  localparam int MFS_F_PSEQ     = 4;
  localparam int MFS_F_CONN     = 5;
  localparam int MFS_F_OVTEMP   = 6;
  localparam int MFS_F_EXT      = 7;
  localparam int MFS_F_WRPAR    = 8;

  // Control register bits.
  localparam int MFS_C_RESET    = 0;
  localparam int MFS_C_DEFLOAD  = 1;

  // Aux input function codes.
  localparam logic [1:0] MFS_AUX_EXTFLT = 2'h0;
  localparam logic [1:0] MFS_AUX_GEN    = 2'h1;

  // ---------------------------------------------------------------
  // Reset values and limits
  // ---------------------------------------------------------------
  localparam logic [15:0] MFS_UV_LVL_RST = 16'h0000;
  localparam logic [15:0] MFS_OV_LVL_RST = 16'hffff;
  localparam logic [15:0] MFS_DLY_RST    = 16'h0001;
  localparam logic [15:0] MFS_TEMP_LIMIT = 16'h0055;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam longint MFS_CLK_HZ      = 200000000;
  localparam longint MFS_EXT_QUAL_MS = 2000;
  localparam longint MFS_EXT_QUAL_CYC = MFS_EXT_QUAL_MS * MFS_CLK_HZ / 1000;
  localparam longint MFS_DLY_UNIT_US = 1000;
  localparam longint MFS_DLY_UNIT_CYC = MFS_DLY_UNIT_US * MFS_CLK_HZ / 1000000;

endpackage

// >>> dv/mfs_checker.sv
`timescale 1ns/100ps
module mfs_checker
  import mfs_pkg::*;
#(
  parameter int VW = 16
) (
  // Clock and reset
  input wire logic          clk,
  input wire logic          rst_n,
  // Inputs
  input wire logic [3:0]    reg_addr,
  input wire logic [15:0]   reg_wdata,
  input wire logic          reg_wr,
  input wire logic [VW-1:0] line_volt,
  input wire logic [2:0]    phase_present,
  input wire logic          phase_seq_ok,
  input wire logic [15:0]   heatsink_temp,
  // Outputs
  input wire logic          param_load_default,
  input wire logic          param_store,
  input wire logic          motor_stop,
  input wire logic          start_block,
  input wire logic          fault_led,
  input wire logic          fault_relay,
  input wire logic [3:0]    trip_code
);
  // ------
  // Checks
  // ------
  logic clr_d;
  logic clr_q;
  assign clr_d = reg_wr && reg_addr == MFS_OFF_CTRL && reg_wdata[MFS_C_RESET];
  always_ff @(posedge clk) begin
    clr_q <= clr_d;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // The trip code trails the trip latch by one cycle, so it must follow the stop output one cycle late.
  property p_outs;
    motor_stop == fault_led && fault_led == fault_relay && (trip_code != 4'h0) == $past(motor_stop);
  endproperty
  a_outs: assert property (p_outs) else $error("trip outputs disagree");
  property p_code; $rose(motor_stop) |-> ##[0:2] trip_code != 4'h0; endproperty
  a_code: assert property (p_code) else $error("no trip code");
  property p_zero; line_volt == '0 |-> ##[1:5] motor_stop; endproperty
  a_zero: assert property (p_zero) else $error("zero voltage not tripped");
  property p_ploss; phase_present != 3'h0 && phase_present != 3'h7 |-> ##[1:5] motor_stop; endproperty
  a_ploss: assert property (p_ploss) else $error("phase loss not tripped");
  property p_pseq; phase_present == 3'h7 && !phase_seq_ok |-> ##[1:5] motor_stop; endproperty
  a_pseq: assert property (p_pseq) else $error("phase order not tripped");
  property p_temp; heatsink_temp > MFS_TEMP_LIMIT |-> ##[1:5] motor_stop; endproperty
  a_temp: assert property (p_temp) else $error("overtemperature not tripped");
  property p_block; $rose(start_block) |-> ##[0:2] motor_stop; endproperty
  a_block: assert property (p_block) else $error("start block without trip");
  property p_latch; $fell(motor_stop) |-> clr_q; endproperty
  a_latch: assert property (p_latch) else $error("trip dropped without reset");
  property p_store; $rose(param_load_default) |=> param_store; endproperty
  a_store: assert property (p_store) else $error("defaults not stored");
endmodule

// >>> dv/mfs_sense_model.sv
`timescale 1ns/100ps
module mfs_sense_model (
  // Sensed values
  output logic [15:0] line_volt,
  output logic [2:0]  phase_present,
  output logic        phase_seq_ok,
  output logic [2:0]  load_conn_ok,
  output logic        scr_shorted,
  output logic [15:0] heatsink_temp,
  output logic        aux_contact,
  output logic        param_xfer_fail
);
  // --------------------------------------------------------
  // Fault f follows the fault bit order; others mean healthy
  // --------------------------------------------------------
  task automatic put(input int f);
    line_volt       <= f == 1 ? 16'h0000 : f == 0 ? 16'h0100 : f == 2 ? 16'h0f00 : 16'h0800;
    phase_present   <= f == 3 ? 3'h5 : 3'h7;
    phase_seq_ok    <= f != 4;
    load_conn_ok    <= f == 5 ? 3'h6 : 3'h7;
    scr_shorted     <= f == 5;
    // The healthy value sits on the limit, which must not trip.
    heatsink_temp   <= f == 6 ? 16'h0056 : 16'h0055;
    aux_contact     <= f == 7;
    param_xfer_fail <= f == 8;
  endtask
  initial put(99);
endmodule

// >>> dv/tb_mfs_supervisor.sv
`timescale 1ns/100ps
module tb_mfs_supervisor;
  import mfs_pkg::*;
  localparam int VW = 16;
  logic          clk, rst_n, reg_wr, reg_rd, phase_seq_ok, scr_shorted, aux_contact;
  logic          param_xfer_fail, key_mode_up, key_mode_store, param_load_default, param_store;
  logic          motor_stop, start_block, fault_led, fault_relay, irq;
  logic [3:0]    reg_addr, trip_code;
  logic [15:0]   reg_wdata, reg_rdata, heatsink_temp;
  logic [VW-1:0] line_volt;
  logic [2:0]    phase_present, load_conn_ok;
  int            fail_count, compares, f;
  mfs_supervisor #(.VW(VW), .EXT_QUAL(50), .DLY_UNIT(4)) dut (.clk, .rst_n, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .line_volt, .phase_present, .phase_seq_ok, .load_conn_ok, .scr_shorted,
    .heatsink_temp, .aux_contact, .param_xfer_fail, .key_mode_up, .key_mode_store, .param_load_default,
    .param_store, .motor_stop, .start_block, .fault_led, .fault_relay, .trip_code, .irq);
  mfs_sense_model sns (.line_volt, .phase_present, .phase_seq_ok, .load_conn_ok, .scr_shorted,
    .heatsink_temp, .aux_contact, .param_xfer_fail);
  // -----
  // Tasks
  // -----
  task automatic test_done();
    if (fail_count == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk("rdata", e, reg_rdata);
  endtask
  // Waiting is bounded so a dead design ends the run instead of hanging it.
  task automatic wt(input int k);
    int i;
    for (i = 0; i < 200 && (k ? param_load_default : motor_stop) !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    if (i == 200) begin
      fail_count++;
      test_done();
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    {rst_n, reg_wr, reg_rd, key_mode_up, key_mode_store} = '0;
    reg_addr  = 4'h0;
    reg_wdata = 16'h0000;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rd(MFS_OFF_MASK, 16'h0000);
    rd(MFS_OFF_OV_LVL, 16'hffff);
    rd(MFS_OFF_UV_DLY, 16'h0001);
    rd(4'hf, 16'h0000);
    wr(MFS_OFF_TRIP, 16'hffff);
    rd(MFS_OFF_TRIP, 16'h0000);
    wr(MFS_OFF_UV_LVL, 16'h0200);
    wr(MFS_OFF_OV_LVL, 16'h0e00);
    wr(MFS_OFF_UV_DLY, 16'h0004);
    wr(MFS_OFF_OV_DLY, 16'h0004);
    for (f = 0; f < MFS_NFLT; f++) begin
      wr(MFS_OFF_MASK, f == 0 ? 16'h0000 : 16'h01ff);
      @(posedge clk);
      sns.put(f);
      if (f inside {0, 2, 7}) begin
        repeat (f == 7 ? 48 : 15) @(posedge clk);
        #1 chk("early trip", 16'h0, motor_stop);
      end
      wt(0);
      @(posedge clk);
      #1 chk("trip code", f + 1, trip_code);
      chk("lamp and relay", 16'h1, fault_led & fault_relay);
      chk("start block", f == 5, start_block);
      rd(MFS_OFF_TRIP, 16'h1 << f);
      rd(MFS_OFF_CTRL, f == 5);
      @(posedge clk);
      sns.put(99);
      repeat (6) @(posedge clk);
      #1 chk("held trip", 16'h1, motor_stop);
      chk("irq", f != 0, irq);
      rd(MFS_OFF_STATUS, 16'h1 << f);
      @(posedge clk);
      #1 chk("irq cleared", 16'h0, irq);
      wr(MFS_OFF_CTRL, 16'h0001);
      repeat (2) @(posedge clk);
      #1 chk("cleared", 16'h0, motor_stop | start_block);
    end
    wr(MFS_OFF_AUXCFG, {14'h0, MFS_AUX_GEN});
    @(posedge clk);
    sns.put(5);
    repeat (10) @(posedge clk);
    #1 chk("generator mode", 16'h0, motor_stop | start_block);
    @(posedge clk);
    sns.put(99);
    key_mode_up    <= 1'b1;
    key_mode_store <= 1'b1;
    wt(1);
    @(posedge clk);
    #1 chk("store", 16'h1, param_store);
    wr(MFS_OFF_CTRL, 16'h0002);
    #1 chk("load by command", 16'h1, param_load_default);
    @(posedge clk);
    #1 chk("store by command", 16'h1, param_store);
    chk("load pulse", 16'h0, param_load_default);
    test_done();
  end
endmodule
bind mfs_supervisor mfs_checker #(.VW(VW)) chk_i (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .line_volt(line_volt), .phase_present(phase_present),
  .phase_seq_ok(phase_seq_ok), .heatsink_temp(heatsink_temp), .param_load_default(param_load_default),
  .param_store(param_store), .motor_stop(motor_stop), .start_block(start_block), .fault_led(fault_led),
  .fault_relay(fault_relay), .trip_code(trip_code));
